// ===== logic/tvm_regbank.sv
`timescale 1ns/1ps
// Summary of operation
// - 8-bit read/write mode register at 00: resolution 7:5, standard 4:3, scaling 2:0.
// - mode register resets to 0x6a: 640x480 input, NTSC, seven-eighths scaling.
// - standard field: 00 PAL, 01 NTSC, 10 PAL-M, 11 NTSC-J.
// - field combination picks one of 29 numbered modes, scaling 5/4 to 7/10.
// - each mode fixes line total, frame total and pixel clock.
// - modes 25-28 are interlaced at their own clocks, with processing bypassed.
// - writes latched by the system clock on a filtered serial clock rising edge only; contents kept in power-down.
module tvm_regbank #(
	// arbitrary value
	parameter logic [6:0] DEV_ADDR = 7'h3a,
	// arbitrary value
	parameter logic [7:0] VERSION = 8'h5a
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_SC,
	input wire logic I_SD,
	output logic O_SD,
	output logic O_SD_OE,
	output tvm_pkg::tvm_mode_t O_MODE,
	output tvm_pkg::tvm_std_t O_STANDARD,
	output logic O_BYPASS
);
	typedef enum {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD} tvm_state_t;
	typedef enum {PH_BITS, PH_ACK_PEND, PH_ACK} tvm_phase_t;

	initial begin
		if (tvm_pkg::REG_DEPTH != (1 << tvm_pkg::REG_AW))
			$error("register depth must cover the full pointer range");
	end

	function automatic tvm_pkg::tvm_mode_t mk(input logic [4:0] n, input logic [10:0] aw,
			input logic [9:0] ah, input logic [10:0] ht, input logic [9:0] vt,
			input logic [25:0] hz, input logic il);
		tvm_pkg::tvm_mode_t m;
		m = '{valid: 1'b1, mode_num: n, act_w: aw, act_h: ah, h_total: ht, v_total: vt,
			pclk_hz: hz, interlaced: il};
		return m;
	endfunction

	// table in mode-number order, by resolution then standard; unlisted codes report invalid
	function automatic tvm_pkg::tvm_mode_t decode_mode(input logic [7:0] d);
		tvm_pkg::tvm_mode_t m;
		m = '0;
		case (d)
			8'b000_00_000: m = mk(5'd0, 11'd512, 10'd384, 11'd840, 10'd500, 26'd21000000, 1'b0);
			8'b000_00_001: m = mk(5'd1, 11'd512, 10'd384, 11'd840, 10'd625, 26'd26250000, 1'b0);
			8'b000_01_000: m = mk(5'd2, 11'd512, 10'd384, 11'd800, 10'd420, 26'd20139860, 1'b0);
			8'b000_01_001: m = mk(5'd3, 11'd512, 10'd384, 11'd784, 10'd525, 26'd24671329, 1'b0);
			8'b001_00_000: m = mk(5'd4, 11'd720, 10'd400, 11'd1125, 10'd500, 26'd28125000, 1'b0);
			8'b001_00_001: m = mk(5'd5, 11'd720, 10'd400, 11'd1116, 10'd625, 26'd34875000, 1'b0);
			8'b001_01_000: m = mk(5'd6, 11'd720, 10'd400, 11'd945, 10'd420, 26'd23790210, 1'b0);
			8'b001_01_001: m = mk(5'd7, 11'd720, 10'd400, 11'd936, 10'd525, 26'd29454545, 1'b0);
			8'b010_00_010: m = mk(5'd8, 11'd640, 10'd400, 11'd1000, 10'd500, 26'd25000000, 1'b0);
			8'b010_00_001: m = mk(5'd9, 11'd640, 10'd400, 11'd1008, 10'd625, 26'd31500000, 1'b0);
			8'b010_01_000: m = mk(5'd10, 11'd640, 10'd400, 11'd840, 10'd420, 26'd21146853, 1'b0);
			8'b010_01_001: m = mk(5'd11, 11'd640, 10'd400, 11'd840, 10'd525, 26'd26433566, 1'b0);
			8'b010_01_010: m = mk(5'd12, 11'd640, 10'd400, 11'd840, 10'd600, 26'd30209790, 1'b0);
			8'b011_00_000: m = mk(5'd13, 11'd640, 10'd480, 11'd840, 10'd500, 26'd21000000, 1'b0);
			8'b011_00_001: m = mk(5'd14, 11'd640, 10'd480, 11'd840, 10'd625, 26'd26250000, 1'b0);
			8'b011_00_011: m = mk(5'd15, 11'd640, 10'd480, 11'd840, 10'd750, 26'd31500000, 1'b0);
			8'b011_01_001: m = mk(5'd16, 11'd640, 10'd480, 11'd784, 10'd525, 26'd24671329, 1'b0);
			8'b011_01_010: m = mk(5'd17, 11'd640, 10'd480, 11'd784, 10'd600, 26'd28195804, 1'b0);
			8'b011_01_011: m = mk(5'd18, 11'd640, 10'd480, 11'd800, 10'd630, 26'd30209790, 1'b0);
			8'b100_00_001: m = mk(5'd19, 11'd800, 10'd600, 11'd944, 10'd625, 26'd29500000, 1'b0);
			8'b100_00_011: m = mk(5'd20, 11'd800, 10'd600, 11'd960, 10'd750, 26'd36000000, 1'b0);
			8'b100_00_100: m = mk(5'd21, 11'd800, 10'd600, 11'd936, 10'd836, 26'd39000000, 1'b0);
			8'b100_01_011: m = mk(5'd22, 11'd800, 10'd600, 11'd1040, 10'd630, 26'd39272727, 1'b0);
			8'b100_01_100: m = mk(5'd23, 11'd800, 10'd600, 11'd1040, 10'd700, 26'd43636364, 1'b0);
			8'b100_01_101: m = mk(5'd24, 11'd800, 10'd600, 11'd1064, 10'd750, 26'd47832168, 1'b0);
			8'b101_00_001: m = mk(5'd25, 11'd720, 10'd576, 11'd864, 10'd625, 26'd13500000, 1'b1);
			8'b101_01_001: m = mk(5'd26, 11'd720, 10'd480, 11'd858, 10'd525, 26'd13500000, 1'b1);
			8'b110_00_001: m = mk(5'd27, 11'd800, 10'd500, 11'd1135, 10'd625, 26'd17734375, 1'b1);
			8'b110_01_001: m = mk(5'd28, 11'd640, 10'd400, 11'd910, 10'd525, 26'd14318182, 1'b1);
			default: m = '0;
		endcase
		return m;
	endfunction

	function automatic logic [7:0] wmask(input logic [5:0] a);
		case (a)
			tvm_pkg::A_MODE, tvm_pkg::A_VBW, tvm_pkg::A_CLK, tvm_pkg::A_SAV, tvm_pkg::A_BLK,
			tvm_pkg::A_HPOS, tvm_pkg::A_VPOS, tvm_pkg::A_PLLM, tvm_pkg::A_PLLN,
			tvm_pkg::A_TST0, tvm_pkg::A_TST2, tvm_pkg::A_TST3: wmask = 8'hff;
			tvm_pkg::A_FFR, tvm_pkg::A_BCO, tvm_pkg::A_PLLC, tvm_pkg::A_TST1: wmask = 8'h3f;
			tvm_pkg::A_IDF: wmask = 8'h6f;
			tvm_pkg::A_POS, tvm_pkg::A_CON, tvm_pkg::A_CIVC: wmask = 8'h07;
			tvm_pkg::A_SYNC, tvm_pkg::A_FSC7, tvm_pkg::A_FSC6, tvm_pkg::A_FSC5,
			tvm_pkg::A_FSC2, tvm_pkg::A_FSC1, tvm_pkg::A_FSC0: wmask = 8'h0f;
			tvm_pkg::A_PWR, tvm_pkg::A_PLLX, tvm_pkg::A_FSC4, tvm_pkg::A_FSC3: wmask = 8'h1f;
			tvm_pkg::A_DET: wmask = 8'h01;
			default: wmask = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rst_val(input logic [5:0] a);
		case (a)
			tvm_pkg::A_MODE: rst_val = tvm_pkg::RST_MODE;
			tvm_pkg::A_FFR: rst_val = tvm_pkg::RST_FFR;
			tvm_pkg::A_CLK: rst_val = tvm_pkg::RST_CLK;
			default: rst_val = tvm_pkg::RST_ZERO;
		endcase
	endfunction

	logic [2:0] sc_s_r;
	logic [2:0] sd_s_r;
	logic sc_q_r;
	logic sd_q_r;
	logic [7:0] mem_r [0:tvm_pkg::REG_DEPTH-1];
	tvm_state_t state_r, state_nxt;
	tvm_phase_t phase_r, phase_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [5:0] ptr_r, ptr_nxt;
	logic own_r, own_nxt;
	logic oe_r, oe_nxt;
	logic wr_en;
	tvm_pkg::tvm_mode_t mode_r;
	tvm_pkg::tvm_std_t std_r;

	// pin inputs count only once the second and third stages agree
	wire sc_ok = sc_s_r[1] == sc_s_r[2];
	wire sd_ok = sd_s_r[1] == sd_s_r[2];
	wire sc_rise = sc_ok & sc_s_r[1] & ~sc_q_r;
	wire sc_fall = sc_ok & ~sc_s_r[1] & sc_q_r;
	wire sc_high = sc_q_r & ~sc_fall;
	wire bus_start = sd_ok & ~sd_s_r[1] & sd_q_r & sc_high;
	wire bus_stop = sd_ok & sd_s_r[1] & ~sd_q_r & sc_high;
	wire [7:0] byte_in = {shift_r[6:0], sd_q_r};
	wire [7:0] mode_reg = mem_r[tvm_pkg::A_MODE];
	wire [7:0] rd_data = (ptr_r == tvm_pkg::A_PTR) ? {2'h0, ptr_r} :
		(ptr_r == tvm_pkg::A_VER) ? VERSION : (mem_r[ptr_r] & wmask(ptr_r));
	wire [7:0] wr_data = byte_in & wmask(ptr_r);
	wire [5:0] ptr_inc = ptr_r + 6'h01;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sc_s_r <= 3'h7;
			sd_s_r <= 3'h7;
			sc_q_r <= 1'b1;
			sd_q_r <= 1'b1;
		end else begin
			sc_s_r <= {sc_s_r[1:0], I_SC};
			sd_s_r <= {sd_s_r[1:0], I_SD};
			if (sc_ok)
				sc_q_r <= sc_s_r[1];
			if (sd_ok)
				sd_q_r <= sd_s_r[1];
		end
	end

	// serial slave: sample on rising clock, drive on falling, ack own address and each byte written
	always_comb begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		cnt_nxt = cnt_r;
		ptr_nxt = ptr_r;
		own_nxt = own_r;
		oe_nxt = oe_r;
		wr_en = 1'b0;
		if (bus_start) begin
			state_nxt = ST_DEV;
			phase_nxt = PH_BITS;
			cnt_nxt = 3'h0;
			oe_nxt = 1'b0;
		end else if (bus_stop) begin
			state_nxt = ST_IDLE;
			phase_nxt = PH_BITS;
			oe_nxt = 1'b0;
		end else if (state_r != ST_IDLE && sc_rise) begin
			if (phase_r == PH_BITS) begin
				shift_nxt = byte_in;
				cnt_nxt = cnt_r + 3'h1;
				if (cnt_r == tvm_pkg::BIT_LAST) begin
					phase_nxt = PH_ACK_PEND;
					own_nxt = 1'b1;
					case (state_r)
						ST_DEV: begin
							if (byte_in[7:1] == DEV_ADDR)
								state_nxt = byte_in[0] ? ST_RD : ST_REG;
							else begin
								state_nxt = ST_IDLE;
								phase_nxt = PH_BITS;
							end
						end
						ST_REG: begin
							ptr_nxt = byte_in[5:0];
							state_nxt = ST_WR;
						end
						ST_WR: begin
							wr_en = 1'b1;
							ptr_nxt = ptr_inc;
						end
						ST_RD: own_nxt = 1'b0;
						default: state_nxt = ST_IDLE;
					endcase
				end
			end else if (phase_r == PH_ACK && !own_r && sd_q_r) begin
				// master declined further data
				state_nxt = ST_IDLE;
				phase_nxt = PH_BITS;
			end
		end else if (state_r != ST_IDLE && sc_fall) begin
			case (phase_r)
				PH_ACK_PEND: begin
					phase_nxt = PH_ACK;
					oe_nxt = own_r;
				end
				PH_ACK: begin
					phase_nxt = PH_BITS;
					oe_nxt = 1'b0;
					if (state_r == ST_RD) begin
						tx_nxt = {rd_data[6:0], 1'b0};
						oe_nxt = ~rd_data[7];
						ptr_nxt = ptr_inc;
					end
				end
				PH_BITS: begin
					if (state_r == ST_RD) begin
						oe_nxt = ~tx_r[7];
						tx_nxt = {tx_r[6:0], 1'b0};
					end
				end
				default: phase_nxt = PH_BITS;
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r <= ST_IDLE;
			phase_r <= PH_BITS;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			cnt_r <= 3'h0;
			ptr_r <= 6'h00;
			own_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			cnt_r <= cnt_nxt;
			ptr_r <= ptr_nxt;
			own_r <= own_nxt;
			oe_r <= oe_nxt;
		end
	end

	// only serial traffic writes here; no power state touches the contents
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < tvm_pkg::REG_DEPTH; i++)
				mem_r[i] <= rst_val(6'(i));
		end else if (wr_en) begin
			mem_r[ptr_r] <= wr_data;
		end
	end

	// decode registered so the outputs never glitch during a write
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode_r <= '0;
			std_r <= tvm_pkg::STD_NTSC;
		end else begin
			mode_r <= decode_mode(mode_reg);
			std_r <= tvm_pkg::tvm_std_t'(mode_reg[tvm_pkg::STD_HI:tvm_pkg::STD_LO]);
		end
	end

	// open drain: only ever pulls low
	assign O_SD = 1'b0;
	assign O_SD_OE = oe_r;
	assign O_MODE = mode_r;
	assign O_STANDARD = std_r;
	assign O_BYPASS = mode_r.interlaced;

	reset_value_a: assert property (@(posedge I_CLK_SYS) $rose(I_RST_N) |->
		mode_reg == tvm_pkg::RST_MODE)
		else $error("mode register not at reset value");
	default_mode_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		mode_reg == tvm_pkg::RST_MODE |=> O_MODE.mode_num == 5'd17 && O_MODE.h_total == 11'd784 &&
		O_MODE.v_total == 10'd600 && O_MODE.pclk_hz == 26'd28195804)
		else $error("default mode totals wrong");
	std_decode_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		mode_reg[4:3] == 2'h3 |=> O_STANDARD == tvm_pkg::STD_NTSC_J)
		else $error("standard field 11 not decoded");
	interlace_mode_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		mode_reg[7:5] == 3'h5 && mode_reg[2:0] == 3'h1 |=> O_MODE.interlaced && O_BYPASS &&
		O_MODE.pclk_hz == 26'd13500000)
		else $error("interlaced mode not flagged");
	invalid_combo_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		mode_reg[7:5] == 3'h7 |=> !O_MODE.valid)
		else $error("unlisted combination reported valid");
	write_store_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		wr_en && ptr_r == tvm_pkg::A_MODE |=> mode_reg == $past(byte_in))
		else $error("mode register write lost");
	write_clock_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		wr_en |-> sc_rise && state_r == ST_WR)
		else $error("write not tied to serial clock edge");
	ptr_step_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		wr_en |=> ptr_r == $past(ptr_inc))
		else $error("pointer did not advance after write");
	idle_release_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		bus_stop |=> !O_SD_OE && state_r == ST_IDLE)
		else $error("data line held after stop");

	mode_write_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		wr_en && ptr_r == tvm_pkg::A_MODE);
	read_byte_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		state_r == ST_RD && phase_r == PH_ACK && !own_r);
	interlaced_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		O_MODE.interlaced);
endmodule

// ===== logic/tvm_pkg.sv
package tvm_pkg;
	localparam int REG_AW = 6;
	localparam int REG_DW = 8;
	localparam int REG_DEPTH = 64;

	localparam logic [5:0] A_MODE = 6'h00;
	localparam logic [5:0] A_FFR = 6'h01;
	localparam logic [5:0] A_VBW = 6'h03;
	localparam logic [5:0] A_IDF = 6'h04;
	localparam logic [5:0] A_CLK = 6'h06;
	localparam logic [5:0] A_SAV = 6'h07;
	localparam logic [5:0] A_POS = 6'h08;
	localparam logic [5:0] A_BLK = 6'h09;
	localparam logic [5:0] A_HPOS = 6'h0a;
	localparam logic [5:0] A_VPOS = 6'h0b;
	localparam logic [5:0] A_SYNC = 6'h0d;
	localparam logic [5:0] A_PWR = 6'h0e;
	localparam logic [5:0] A_DET = 6'h10;
	localparam logic [5:0] A_CON = 6'h11;
	localparam logic [5:0] A_PLLX = 6'h13;
	localparam logic [5:0] A_PLLM = 6'h14;
	localparam logic [5:0] A_PLLN = 6'h15;
	localparam logic [5:0] A_BCO = 6'h17;
	localparam logic [5:0] A_FSC7 = 6'h18;
	localparam logic [5:0] A_FSC6 = 6'h19;
	localparam logic [5:0] A_FSC5 = 6'h1a;
	localparam logic [5:0] A_FSC4 = 6'h1b;
	localparam logic [5:0] A_FSC3 = 6'h1c;
	localparam logic [5:0] A_FSC2 = 6'h1d;
	localparam logic [5:0] A_FSC1 = 6'h1e;
	localparam logic [5:0] A_FSC0 = 6'h1f;
	localparam logic [5:0] A_PLLC = 6'h20;
	localparam logic [5:0] A_CIVC = 6'h21;
	localparam logic [5:0] A_VER = 6'h25;
	localparam logic [5:0] A_TST0 = 6'h26;
	localparam logic [5:0] A_TST1 = 6'h27;
	localparam logic [5:0] A_TST2 = 6'h28;
	localparam logic [5:0] A_TST3 = 6'h29;
	localparam logic [5:0] A_PTR = 6'h3f;

	localparam logic [7:0] RST_MODE = 8'h6a;
	localparam logic [7:0] RST_FFR = 8'h32;
	localparam logic [7:0] RST_CLK = 8'h10;
	localparam logic [7:0] RST_ZERO = 8'h00;

	localparam int RES_HI = 7;
	localparam int RES_LO = 5;
	localparam int STD_HI = 4;
	localparam int STD_LO = 3;
	localparam int SCL_HI = 2;
	localparam int SCL_LO = 0;

	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum logic [1:0] {STD_PAL, STD_NTSC, STD_PAL_M, STD_NTSC_J} tvm_std_t;

	typedef struct packed {
		logic valid;
		logic [4:0] mode_num;
		logic [10:0] act_w;
		logic [9:0] act_h;
		logic [10:0] h_total;
		logic [9:0] v_total;
		logic [25:0] pclk_hz;
		logic interlaced;
	} tvm_mode_t;
endpackage

// ===== verif/tvm_host_model.sv
`timescale 1ns/1ps
module tvm_host_model #(
	// arbitrary value
	parameter logic [6:0] DEV_ADDR = 7'h3a
) (
	input wire logic i_clk,
	input wire logic i_sd_oe,
	output logic o_sc,
	output logic o_sd
);
	// sc phases kept above four clocks so the pin filter sees each edge
	localparam int HALF = 6;
	logic sd_low_r;
	int miss_cnt;
	// open-drain line with pull-up: released means high
	assign o_sd = !(sd_low_r || i_sd_oe);
	initial begin
		o_sc = 1'b1;
		sd_low_r = 1'b0;
		miss_cnt = 0;
	end
	task automatic half();
		repeat (HALF) @(negedge i_clk);
	endtask
	// data only moves while sc is low, so no false start or stop
	task automatic clk_bit(input logic b, output logic s);
		sd_low_r = !b;
		half();
		o_sc = 1'b1;
		half();
		s = o_sd;
		o_sc = 1'b0;
		half();
	endtask
	task automatic start();
		sd_low_r = 1'b0;
		half();
		o_sc = 1'b1;
		half();
		sd_low_r = 1'b1;
		half();
		o_sc = 1'b0;
		half();
	endtask
	task automatic stop();
		sd_low_r = 1'b1;
		half();
		o_sc = 1'b1;
		half();
		sd_low_r = 1'b0;
		half();
	endtask
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		ack = !s;
	endtask
	task automatic send(input logic [7:0] d);
		logic k;
		byte_out(d, k);
		if (!k) begin
			miss_cnt++;
		end
	endtask
	// writes move only with sc edges; bench sends listed codes except on purpose
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		start();
		send({DEV_ADDR, 1'b0});
		send(a);
		send(d);
		stop();
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		logic s;
		start();
		send({DEV_ADDR, 1'b0});
		send(a);
		start();
		send({DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(1'b1, s);
		stop();
	endtask
endmodule

// ===== verif/tv_encoder_mode_register_bank_test.sv
`timescale 1ns/1ps
module tv_encoder_mode_register_bank_test;
	logic clk;
	logic rst_n;
	wire sc;
	wire sd;
	wire sd_out;
	wire sd_oe;
	tvm_pkg::tvm_mode_t mode;
	tvm_pkg::tvm_std_t std_sel;
	wire bypass;
	int err_total;
	int samples_checked;
	logic k;
	logic [7:0] c;

	tvm_regbank tvm_regbank_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SC(sc), .I_SD(sd),
		.O_SD(sd_out), .O_SD_OE(sd_oe), .O_MODE(mode), .O_STANDARD(std_sel), .O_BYPASS(bypass));
	tvm_host_model tvm_host_model_i (.i_clk(clk), .i_sd_oe(sd_oe), .o_sc(sc), .o_sd(sd));

	always #12.5 clk = ~clk;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_mode(input logic [4:0] m, input logic [7:0] cd, input logic [10:0] aw,
		input logic [9:0] ah, input logic [10:0] ht, input logic [9:0] vt, input logic [25:0] hz);
		tvm_pkg::tvm_mode_t exp;
		logic [7:0] rd;
		exp = '{1'b1, m, aw, ah, ht, vt, hz, m >= 5'd25};
		tvm_host_model_i.wr_reg(8'h00, cd);
		repeat (4) @(negedge clk);
		chk("mode decode", 80'(exp), 80'(mode));
		chk("standard", 80'(cd[4:3]), 80'(std_sel));
		chk("bypass", 80'(exp.interlaced), 80'(bypass));
		tvm_host_model_i.rd_reg(8'h00, rd);
		chk("mode readback", 80'(cd), 80'(rd));
	endtask

	task automatic do_reset();
		logic [7:0] rd;
		tvm_pkg::tvm_mode_t exp;
		exp = '{1'b1, 5'd17, 11'd640, 10'd480, 11'd784, 10'd600, 26'd28195804, 1'b0};
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("reset mode", 80'(exp), 80'(mode));
		chk("reset standard", 80'(tvm_pkg::STD_NTSC), 80'(std_sel));
		chk("data drive level", 80'h0, 80'(sd_out));
		chk("data released", 80'h0, 80'(sd_oe));
		tvm_host_model_i.rd_reg(8'h00, rd);
		chk("reset readback", 80'(8'h6a), 80'(rd));
	endtask

	initial begin
		#2400000;
		err_total++;
		print_verdict();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		err_total = 0;
		samples_checked = 0;
		do_reset();
		chk_mode(5'd0, 8'h00, 11'd512, 10'd384, 11'd840, 10'd500, 26'd21000000);
		chk_mode(5'd1, 8'h01, 11'd512, 10'd384, 11'd840, 10'd625, 26'd26250000);
		chk_mode(5'd2, 8'h08, 11'd512, 10'd384, 11'd800, 10'd420, 26'd20139860);
		chk_mode(5'd3, 8'h09, 11'd512, 10'd384, 11'd784, 10'd525, 26'd24671329);
		chk_mode(5'd4, 8'h20, 11'd720, 10'd400, 11'd1125, 10'd500, 26'd28125000);
		chk_mode(5'd5, 8'h21, 11'd720, 10'd400, 11'd1116, 10'd625, 26'd34875000);
		chk_mode(5'd6, 8'h28, 11'd720, 10'd400, 11'd945, 10'd420, 26'd23790210);
		chk_mode(5'd7, 8'h29, 11'd720, 10'd400, 11'd936, 10'd525, 26'd29454545);
		chk_mode(5'd8, 8'h42, 11'd640, 10'd400, 11'd1000, 10'd500, 26'd25000000);
		chk_mode(5'd9, 8'h41, 11'd640, 10'd400, 11'd1008, 10'd625, 26'd31500000);
		chk_mode(5'd10, 8'h48, 11'd640, 10'd400, 11'd840, 10'd420, 26'd21146853);
		chk_mode(5'd11, 8'h49, 11'd640, 10'd400, 11'd840, 10'd525, 26'd26433566);
		chk_mode(5'd12, 8'h4a, 11'd640, 10'd400, 11'd840, 10'd600, 26'd30209790);
		chk_mode(5'd13, 8'h60, 11'd640, 10'd480, 11'd840, 10'd500, 26'd21000000);
		chk_mode(5'd14, 8'h61, 11'd640, 10'd480, 11'd840, 10'd625, 26'd26250000);
		chk_mode(5'd15, 8'h63, 11'd640, 10'd480, 11'd840, 10'd750, 26'd31500000);
		chk_mode(5'd16, 8'h69, 11'd640, 10'd480, 11'd784, 10'd525, 26'd24671329);
		chk_mode(5'd17, 8'h6a, 11'd640, 10'd480, 11'd784, 10'd600, 26'd28195804);
		chk_mode(5'd18, 8'h6b, 11'd640, 10'd480, 11'd800, 10'd630, 26'd30209790);
		chk_mode(5'd19, 8'h81, 11'd800, 10'd600, 11'd944, 10'd625, 26'd29500000);
		chk_mode(5'd20, 8'h83, 11'd800, 10'd600, 11'd960, 10'd750, 26'd36000000);
		chk_mode(5'd21, 8'h84, 11'd800, 10'd600, 11'd936, 10'd836, 26'd39000000);
		chk_mode(5'd22, 8'h8b, 11'd800, 10'd600, 11'd1040, 10'd630, 26'd39272727);
		chk_mode(5'd23, 8'h8c, 11'd800, 10'd600, 11'd1040, 10'd700, 26'd43636364);
		chk_mode(5'd24, 8'h8d, 11'd800, 10'd600, 11'd1064, 10'd750, 26'd47832168);
		chk_mode(5'd25, 8'ha1, 11'd720, 10'd576, 11'd864, 10'd625, 26'd13500000);
		chk_mode(5'd26, 8'ha9, 11'd720, 10'd480, 11'd858, 10'd525, 26'd13500000);
		chk_mode(5'd27, 8'hc1, 11'd800, 10'd500, 11'd1135, 10'd625, 26'd17734375);
		chk_mode(5'd28, 8'hc9, 11'd640, 10'd400, 11'd910, 10'd525, 26'd14318182);
		// pal-m and ntsc-j have no listed mode; standard must still follow the field
		for (int v = 2; v < 4; v++) begin
			c = {3'b011, 2'(v), 3'b010};
			tvm_host_model_i.wr_reg(8'h00, c);
			repeat (4) @(negedge clk);
			chk("unlisted mode", 80'h0, 80'(mode));
			chk("unlisted standard", 80'(v), 80'(std_sel));
		end
		tvm_host_model_i.start();
		tvm_host_model_i.byte_out(8'hee, k);
		tvm_host_model_i.stop();
		chk("foreign address ack", 80'h0, 80'(k));
		do_reset();
		chk("device acks", 80'h0, 80'(tvm_host_model_i.miss_cnt));
		print_verdict();
	end
endmodule
